/* File: scr_serial_channel.sv */
`timescale 1ns/10ps
`default_nettype none
module scr_serial_channel (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Serial pins
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic counter_a_pin_i,
  output logic counter_a_pin_o,
  output logic counter_a_pin_oe_o,
  // Interrupt request
  output logic irq_o
);
  import scr_pkg::*;

  typedef struct packed {
    logic [1:0] rxd_s;
    logic [1:0] ca_s;
    logic ca_d;
    logic rxd_d;
    logic [7:0] ctrl;
    logic [1:0] mode;
    logic [1:0] ie;
    logic [15:0] cnt;
    logic [15:0] latch;
    logic uf_flag;
    logic sub_ph;
    logic [3:0] tx_ph;
    logic [7:0] tx_data;
    logic [11:0] tx_sh;
    logic [3:0] tx_bits;
    logic tx_busy;
    logic txd;
    logic ca_o;
    logic ca_oe;
    logic [7:0] st;
    scr_rx_t rx_state;
    logic [2:0] rx_sub;
    logic [3:0] rx_bits;
    logic [8:0] rx_sh;
    logic [7:0] rx_data;
    logic [6:0] rx_ones;
    logic wait_r;
    logic [7:0] rdata;
    logic irq;
  } scr_state_t;

  scr_state_t s_r;
  scr_state_t s_nxt;

  // ==========================================================
  // Frame builders
  function automatic logic [7:0] scr_mask(input logic [1:0] len);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - len);
    return m;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [5:0] idx;
    logic acc;
    logic wr;
    logic rd;
    logic uf;
    logic sub;
    logic bit_end;
    logic tx_en;
    logic rx_en;
    logic load;
    logic [3:0] nbits;
    logic [7:0] d;
    logic done;
    logic perr;
    logic ferr;
    logic [7:0] rdat;
    logic rx_irq;
    logic tx_irq;
    idx = avs_address_i[7:2];
    acc = avs_read_i | avs_write_i;
    wr = avs_write_i & ~s_r.wait_r & avs_byteenable_i[0];
    rd = avs_read_i & ~s_r.wait_r;
    tx_en = s_r.ctrl[SCR_CTL_TX_EN];
    rx_en = s_r.ctrl[SCR_CTL_RX_EN];
    nbits = SCR_MIN_CHAR + {2'h0, s_r.ctrl[1:0]};
    rx_irq = rx_en & (|s_r.st[3:0]);
    tx_irq = tx_en & s_r.st[SCR_ST_TX_EMPTY] & (s_r.st[SCR_ST_EOT] | s_r.st[SCR_ST_UNDERRUN]);
    sub = 1'b0;
    bit_end = 1'b0;
    rdat = 8'h00;
    uf = 1'b0;
    load = 1'b0;
    done = 1'b0;
    perr = 1'b0;
    ferr = 1'b0;
    d = 8'h00;
    s_nxt = s_r;
    s_nxt.rxd_s = {s_r.rxd_s[0], rxd_i};
    s_nxt.ca_s = {s_r.ca_s[0], counter_a_pin_i};
    s_nxt.ca_d = s_r.ca_s[1];
    s_nxt.rxd_d = s_r.rxd_s[1];

    // ----------------------------------------------------
    // Rate counter
    if (tx_en | (rx_en & ~s_r.ctrl[SCR_CTL_RX_SR])) begin
      s_nxt.mode = SCR_MODE_INTERVAL;
    end
    if (s_r.mode == SCR_MODE_INTERVAL) begin
      if (s_r.cnt == 16'h0000) begin
        s_nxt.cnt = s_r.latch;
        uf = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
      end
    end
    sub = uf & s_r.sub_ph;
    if (uf) begin
      s_nxt.sub_ph = ~s_r.sub_ph;
      s_nxt.tx_ph = s_r.tx_ph + 4'h1;
    end
    bit_end = uf & (s_r.tx_ph == SCR_TX_PH_LAST);

    // ----------------------------------------------------
    // Register writes
    if (wr) begin
      case (idx)
        SCR_IDX_MODE: s_nxt.mode = avs_writedata_i[1:0];
        SCR_IDX_CTRL: s_nxt.ctrl = avs_writedata_i[7:0];
        SCR_IDX_STATUS: begin
          if (avs_writedata_i[SCR_ST_WAKEUP]) begin
            s_nxt.st[SCR_ST_WAKEUP] = 1'b1;
          end
          if (avs_writedata_i[SCR_ST_EOT]) begin
            s_nxt.st[SCR_ST_EOT] = 1'b1;
          end
        end
        SCR_IDX_DATA: begin
          s_nxt.tx_data = avs_writedata_i[7:0];
          s_nxt.st[SCR_ST_EOT] = 1'b0;
          s_nxt.st[SCR_ST_TX_EMPTY] = 1'b0;
        end
        SCR_IDX_CNT_LO: s_nxt.latch[7:0] = avs_writedata_i[7:0];
        SCR_IDX_CNT_HI: s_nxt.latch[15:8] = avs_writedata_i[7:0];
        SCR_IDX_LOAD: begin
          s_nxt.latch[15:8] = avs_writedata_i[7:0];
          s_nxt.cnt = {avs_writedata_i[7:0], s_r.latch[7:0]};
          s_nxt.uf_flag = 1'b0;
        end
        SCR_IDX_IRQ: s_nxt.ie = avs_writedata_i[1:0];
        default: begin
        end
      endcase
    end
    if (rd && idx == SCR_IDX_CNT_LO) begin
      s_nxt.uf_flag = 1'b0;
    end
    if (rd && idx == SCR_IDX_DATA) begin
      s_nxt.st[3:0] = 4'h0;
    end
    // Underflow set after the clears so a coincident event is kept
    if (uf) begin
      s_nxt.uf_flag = 1'b1;
    end

    // ----------------------------------------------------
    // Transmitter
    if (tx_en) begin
      if (!s_r.tx_busy) begin
        load = ~s_r.st[SCR_ST_TX_EMPTY];
        s_nxt.txd = 1'b1;
        s_nxt.ca_o = 1'b1;
        if (load) begin
          s_nxt.tx_ph = 4'h0;
        end
      end else if (bit_end) begin
        if (s_r.tx_bits > 4'h1) begin
          s_nxt.tx_sh = {1'b1, s_r.tx_sh[11:1]};
          s_nxt.txd = s_r.tx_sh[1];
          s_nxt.tx_bits = s_r.tx_bits - 4'h1;
        end else if (!s_r.st[SCR_ST_TX_EMPTY]) begin
          load = 1'b1;
        end else begin
          s_nxt.tx_busy = 1'b0;
          s_nxt.txd = 1'b1;
          s_nxt.ca_o = 1'b1;
          s_nxt.st[SCR_ST_UNDERRUN] = 1'b1;
        end
      end
      if (load) begin
        d = s_r.tx_data;
        s_nxt.tx_busy = 1'b1;
        s_nxt.st[SCR_ST_TX_EMPTY] = 1'b1;
        s_nxt.st[SCR_ST_UNDERRUN] = 1'b0;
        if (s_r.ctrl[SCR_CTL_TX_SR]) begin
          s_nxt.tx_sh = {4'hF, d};
          s_nxt.tx_bits = SCR_SR_BITS;
          s_nxt.txd = d[0];
        end else begin
          d = d & scr_mask(s_r.ctrl[1:0]);
          s_nxt.tx_sh = {3'h7, d, 1'b0} | ~({3'h0, scr_mask(s_r.ctrl[1:0]), 1'b1});
          if (s_r.ctrl[SCR_CTL_PAR_EN]) begin
            s_nxt.tx_sh[nbits + 4'h1] = (^d) ^ s_r.ctrl[SCR_CTL_PAR_ODD];
          end
          // Either one parity plus one stop or two stops: same length
          s_nxt.tx_bits = nbits + 4'h3;
          s_nxt.txd = 1'b0;
        end
      end
      if (s_r.ctrl[SCR_CTL_TX_SR] && s_nxt.tx_busy) begin
        s_nxt.ca_o = (s_nxt.tx_ph >= SCR_TX_PH_HALF);
      end
      s_nxt.ca_oe = s_r.ctrl[SCR_CTL_TX_SR];
    end else begin
      s_nxt.tx_busy = 1'b0;
      s_nxt.txd = 1'b1;
      s_nxt.ca_o = 1'b1;
      s_nxt.ca_oe = 1'b0;
    end

    // ----------------------------------------------------
    // Receiver
    if (!rx_en) begin
      s_nxt.rx_state = SCR_RX_IDLE;
      s_nxt.rx_bits = 4'h0;
    end else if (s_r.ctrl[SCR_CTL_RX_SR]) begin
      s_nxt.rx_state = SCR_RX_IDLE;
      // Remote clock is slow enough for a synchronised edge detect
      if (s_r.ca_s[1] && !s_r.ca_d) begin
        s_nxt.rx_sh[s_r.rx_bits[2:0]] = s_r.rxd_s[1];
        s_nxt.rx_bits = s_r.rx_bits + 4'h1;
        if (s_r.rx_bits == 4'h7) begin
          s_nxt.rx_bits = 4'h0;
          done = 1'b1;
          d = {s_r.rxd_s[1], s_r.rx_sh[6:0]};
        end
      end
    end else begin
      if (sub) begin
        if (!s_r.rxd_s[1]) begin
          s_nxt.rx_ones = 7'h00;
        end else if (s_r.rx_ones == SCR_IDLE_ONES) begin
          s_nxt.rx_ones = 7'h00;
          s_nxt.st[SCR_ST_WAKEUP] = 1'b0;
        end else begin
          s_nxt.rx_ones = s_r.rx_ones + 7'h01;
        end
      end
      case (s_r.rx_state)
        SCR_RX_IDLE: begin
          // Start needs a falling edge: a low stop slot must not restart reception
          if (!s_r.rxd_s[1] && s_r.rxd_d) begin
            s_nxt.rx_state = SCR_RX_START;
            s_nxt.rx_sub = 3'h0;
          end
        end
        SCR_RX_START: begin
          if (sub) begin
            if (s_r.rxd_s[1]) begin
              s_nxt.rx_state = SCR_RX_IDLE;
            end else if (s_r.rx_sub == SCR_RX_HALF) begin
              s_nxt.rx_state = SCR_RX_DATA;
              s_nxt.rx_sub = 3'h0;
              s_nxt.rx_bits = 4'h0;
              s_nxt.rx_sh = 9'h000;
            end else begin
              s_nxt.rx_sub = s_r.rx_sub + 3'h1;
            end
          end
        end
        SCR_RX_DATA: begin
          if (sub) begin
            s_nxt.rx_sub = s_r.rx_sub + 3'h1;
            if (s_r.rx_sub == SCR_RX_CENTRE) begin
              s_nxt.rx_sh[s_r.rx_bits] = s_r.rxd_s[1];
              s_nxt.rx_bits = s_r.rx_bits + 4'h1;
              if (s_r.rx_bits + 4'h1 == nbits + {3'h0, s_r.ctrl[SCR_CTL_PAR_EN]}) begin
                s_nxt.rx_state = SCR_RX_STOP;
              end
            end
          end
        end
        SCR_RX_STOP: begin
          if (sub) begin
            s_nxt.rx_sub = s_r.rx_sub + 3'h1;
            if (s_r.rx_sub == SCR_RX_CENTRE) begin
              s_nxt.rx_state = SCR_RX_IDLE;
              s_nxt.rx_bits = 4'h0;
              done = 1'b1;
              d = s_r.rx_sh[7:0] & scr_mask(s_r.ctrl[1:0]);
              ferr = ~s_r.rxd_s[1];
              if (s_r.ctrl[SCR_CTL_PAR_EN]) begin
                perr = s_r.rx_sh[nbits] ^ (^d) ^ s_r.ctrl[SCR_CTL_PAR_ODD];
              end
            end
          end
        end
        default: s_nxt.rx_state = SCR_RX_IDLE;
      endcase
    end
    // Transfer into the data register; wake-up keeps status quiet
    if (done && !s_r.st[SCR_ST_WAKEUP]) begin
      s_nxt.rx_data = d;
      if (s_r.st[SCR_ST_RX_FULL]) begin
        s_nxt.st[SCR_ST_OVERRUN] = 1'b1;
      end
      if (perr) begin
        s_nxt.st[SCR_ST_PAR_ERR] = 1'b1;
      end
      if (ferr) begin
        s_nxt.st[SCR_ST_FRM_ERR] = 1'b1;
      end
      if (!perr && !ferr) begin
        s_nxt.st[SCR_ST_RX_FULL] = 1'b1;
      end
    end

    // ----------------------------------------------------
    // Flags and bus answer
    s_nxt.irq = (rx_irq & s_r.ie[SCR_IRQ_RX_IE]) | (tx_irq & s_r.ie[SCR_IRQ_TX_IE]);
    case (idx)
      SCR_IDX_MODE: rdat = {6'h00, s_r.mode};
      SCR_IDX_CTRL: rdat = s_r.ctrl;
      SCR_IDX_STATUS: begin
        rdat = s_r.st;
        // End-of-transmission hides empty until an under-run
        rdat[SCR_ST_TX_EMPTY] = s_r.st[SCR_ST_TX_EMPTY] &
          (~s_r.st[SCR_ST_EOT] | s_r.st[SCR_ST_UNDERRUN]);
      end
      SCR_IDX_DATA: rdat = s_r.rx_data;
      SCR_IDX_CNT_LO: rdat = s_r.cnt[7:0];
      SCR_IDX_CNT_HI: rdat = s_r.cnt[15:8];
      SCR_IDX_IRQ: begin
        rdat = {6'h00, s_r.ie};
        rdat[SCR_IRQ_UF] = s_r.uf_flag;
        rdat[SCR_IRQ_RX] = rx_irq;
        rdat[SCR_IRQ_TX] = tx_irq;
      end
      default: rdat = 8'h00;
    endcase
    // One wait cycle, then a single-cycle acknowledge
    s_nxt.wait_r = ~(acc & s_r.wait_r);
    if (acc && s_r.wait_r) begin
      s_nxt.rdata = avs_read_i ? rdat : 8'h00;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
      s_r.ctrl <= SCR_CTRL_RST;
      s_r.mode <= SCR_MODE_RST;
      s_r.latch <= SCR_LATCH_RST;
      s_r.cnt <= SCR_LATCH_RST;
      s_r.st <= 8'h00;
      s_r.st[SCR_ST_TX_EMPTY] <= 1'b1;
      s_r.rx_state <= SCR_RX_IDLE;
      s_r.txd <= 1'b1;
      s_r.ca_o <= 1'b1;
      s_r.wait_r <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_o = {24'h000000, s_r.rdata};
  assign avs_waitrequest_o = s_r.wait_r;
  assign txd_o = s_r.txd;
  assign counter_a_pin_o = s_r.ca_o;
  assign counter_a_pin_oe_o = s_r.ca_oe;
  assign irq_o = s_r.irq;
endmodule
`default_nettype wire

/* File: scr_pkg.sv */
package scr_pkg;
  // ==========================================================
  // Register indices (byte address = 4 * index)
  localparam logic [5:0] SCR_IDX_MODE = 6'h14;
  localparam logic [5:0] SCR_IDX_CTRL = 6'h15;
  localparam logic [5:0] SCR_IDX_STATUS = 6'h16;
  localparam logic [5:0] SCR_IDX_DATA = 6'h17;
  localparam logic [5:0] SCR_IDX_CNT_LO = 6'h18;
  localparam logic [5:0] SCR_IDX_CNT_HI = 6'h19;
  localparam logic [5:0] SCR_IDX_LOAD = 6'h1A;
  localparam logic [5:0] SCR_IDX_IRQ = 6'h1B;
  // ==========================================================
  // Serial control fields
  localparam int SCR_CTL_TX_EN = 7;
  localparam int SCR_CTL_RX_EN = 6;
  localparam int SCR_CTL_TX_SR = 5;
  localparam int SCR_CTL_RX_SR = 4;
  localparam int SCR_CTL_PAR_EN = 3;
  localparam int SCR_CTL_PAR_ODD = 2;
  // ==========================================================
  // Serial status fields
  localparam int SCR_ST_RX_FULL = 0;
  localparam int SCR_ST_OVERRUN = 1;
  localparam int SCR_ST_PAR_ERR = 2;
  localparam int SCR_ST_FRM_ERR = 3;
  localparam int SCR_ST_WAKEUP = 4;
  localparam int SCR_ST_EOT = 5;
  localparam int SCR_ST_TX_EMPTY = 6;
  localparam int SCR_ST_UNDERRUN = 7;
  // ==========================================================
  // Flag register fields
  localparam int SCR_IRQ_RX_IE = 0;
  localparam int SCR_IRQ_TX_IE = 1;
  localparam int SCR_IRQ_UF = 4;
  localparam int SCR_IRQ_RX = 6;
  localparam int SCR_IRQ_TX = 7;
  // ==========================================================
  // Reset values and timing counts
  localparam logic [7:0] SCR_CTRL_RST = 8'h00;
  localparam logic [1:0] SCR_MODE_RST = 2'h0;
  localparam logic [1:0] SCR_MODE_INTERVAL = 2'h0;
  localparam logic [15:0] SCR_LATCH_RST = 16'hFFFF;
  localparam logic [3:0] SCR_TX_PH_LAST = 4'hF;
  localparam logic [3:0] SCR_TX_PH_HALF = 4'h8;
  localparam logic [2:0] SCR_RX_HALF = 3'h3;
  localparam logic [2:0] SCR_RX_CENTRE = 3'h7;
  localparam logic [6:0] SCR_IDLE_ONES = 7'h4F;
  localparam logic [3:0] SCR_SR_BITS = 4'h8;
  localparam logic [3:0] SCR_MIN_CHAR = 4'h5;
  typedef enum logic [1:0] {SCR_RX_IDLE, SCR_RX_START, SCR_RX_DATA, SCR_RX_STOP} scr_rx_t;
endpackage

/* File: scr_serial_channel_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module scr_serial_channel_sva (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic rxd_i,
  input wire logic txd_o,
  input wire logic counter_a_pin_i,
  input wire logic counter_a_pin_o,
  input wire logic counter_a_pin_oe_o,
  input wire logic irq_o
);
  import scr_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic acc_w;
  logic [7:0] ctrl_r;
  logic [1:0] ie_r;
  // ==========================================================
  // Shadow of the control and enable registers, seen from the bus
  assign acc_w = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= 8'h00;
      ie_r <= 2'h0;
    end else if (acc_w && avs_address_i[7:2] == SCR_IDX_CTRL) begin
      ctrl_r <= avs_writedata_i[7:0];
    end else if (acc_w && avs_address_i[7:2] == SCR_IDX_IRQ) begin
      ie_r <= avs_writedata_i[1:0];
    end
  end
  // ==========================================================
  // Checks
  chk_wait_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one wait state");
  chk_wait_single: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  chk_unmapped_zero: assert property (
    avs_read_i && !avs_waitrequest_o
    && (avs_address_i[7:2] < SCR_IDX_MODE || avs_address_i[7:2] > SCR_IDX_IRQ)
    |-> avs_readdata_o == 32'h0)
    else $error("unmapped read returned data");
  chk_rdata_upper: assert property (
    !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  chk_tx_off_idle: assert property (
    $stable(ctrl_r) && !ctrl_r[SCR_CTL_TX_EN] |-> txd_o && counter_a_pin_o)
    else $error("serial out active with transmitter off");
  chk_oe_shift: assert property (
    $stable(ctrl_r)
    |-> counter_a_pin_oe_o == (ctrl_r[SCR_CTL_TX_EN] && ctrl_r[SCR_CTL_TX_SR]))
    else $error("shift clock enable does not follow the mode");
  chk_shift_stable: assert property (
    counter_a_pin_oe_o && $rose(counter_a_pin_o) |-> $stable(txd_o))
    else $error("shift data moved on the rising shift clock");
  chk_irq_masked: assert property (
    ie_r == 2'h0 && $past(ie_r) == 2'h0 |-> !irq_o)
    else $error("interrupt with both enables clear");
  chk_off_no_irq: assert property (
    ctrl_r[7:6] == 2'h0 && $past(ctrl_r[7:6]) == 2'h0 |-> !irq_o)
    else $error("interrupt with channel disabled");
  cov_shift_clk: cover property (counter_a_pin_oe_o && $rose(counter_a_pin_o));
  cov_irq: cover property ($rose(irq_o));
  cov_unmapped: cover property (avs_read_i && !avs_waitrequest_o && avs_address_i == 8'hFC);
endmodule
`default_nettype wire

/* File: scr_remote_node.sv */
`timescale 1ns/10ps
`default_nettype none
module scr_remote_node (
  // Clock
  input wire logic sys_clk_i,
  // From the channel
  input wire logic txd_i,
  input wire logic shift_clk_i,
  // To the channel
  output logic rxd_o,
  output logic shift_clk_o
);
  int bit_cyc = 32;
  // Pull-ups: both lines rest high whenever this node lets go
  initial begin
    rxd_o = 1'b1;
    shift_clk_o = 1'b1;
  end
  task automatic hold(input logic v, input int n);
    rxd_o <= v;
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic send_async(input logic [7:0] d, input int nb, input logic par_on,
                            input logic par_v, input logic stop_v);
    hold(1'b0, bit_cyc);
    for (int i = 0; i < nb; i++) hold(d[i], bit_cyc);
    if (par_on) hold(par_v, bit_cyc);
    hold(stop_v, bit_cyc);
    hold(1'b1, 2 * bit_cyc);
  endtask
  // Eight-cycle shift clock period: four cycles low, then four cycles high
  task automatic send_shift(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      rxd_o <= d[i];
      shift_clk_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      shift_clk_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
    end
    rxd_o <= 1'b1;
  endtask
  // Data, then parity or second stop, then stop: always nb+2 slots
  task automatic recv_async(input int nb, output logic [9:0] got);
    int k;
    got = 10'h000;
    for (k = 0; k < 20000 && txd_i !== 1'b0; k++) @(posedge sys_clk_i);
    repeat (bit_cyc / 2) @(posedge sys_clk_i);
    for (int i = 0; i < nb + 2; i++) begin
      repeat (bit_cyc) @(posedge sys_clk_i);
      got[i] = txd_i;
    end
    repeat (bit_cyc / 2 + 2) @(posedge sys_clk_i);
  endtask
  task automatic recv_shift(output logic [7:0] got);
    int k;
    got = 8'h00;
    for (int i = 0; i < 8; i++) begin
      for (k = 0; k < 2000 && shift_clk_i !== 1'b0; k++) @(posedge sys_clk_i);
      for (k = 0; k < 2000 && shift_clk_i !== 1'b1; k++) @(posedge sys_clk_i);
      got[i] = txd_i;
    end
  endtask
endmodule
`default_nettype wire

/* File: scr_serial_channel_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module scr_serial_channel_tb_top;
  import scr_pkg::*;
  logic sys_clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic rxd_i, txd_o, counter_a_pin_i, counter_a_pin_o, counter_a_pin_oe_o, far_clk;
  logic [7:0] avs_address_i, m, dat, g8;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [3:0] avs_byteenable_i;
  logic [9:0] got, exp_f;
  logic pe, odd, p;
  int err_total, n_tests, len;
  scr_serial_channel scr_serial_channel_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .rxd_i(rxd_i), .txd_o(txd_o), .counter_a_pin_i(counter_a_pin_i),
    .counter_a_pin_o(counter_a_pin_o), .counter_a_pin_oe_o(counter_a_pin_oe_o),
    .irq_o(irq_o));
  scr_remote_node scr_remote_node_i (.sys_clk_i(sys_clk_i), .txd_i(txd_o),
    .shift_clk_i(counter_a_pin_i), .rxd_o(rxd_i), .shift_clk_o(far_clk));
  // Shared counter pin: whoever enables drives, else the far node
  assign counter_a_pin_i = counter_a_pin_oe_o ? counter_a_pin_o : far_clk;
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================================
  // Bus and checking tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int k;
    @(posedge sys_clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {24'h0, d};
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (k == 50) err_total++;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [7:0] msk, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rd & {24'h0, msk}, {24'h0, exp});
  endtask
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Whole run is about 14k cycles; the 75k-cycle limit means a hang
  initial begin
    #600000;
    err_total++;
    give_verdict();
  end
  // ==========================================================
  // Main sequence
  initial begin
    err_total = 0;
    n_tests = 0;
    rstn_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    repeat (3) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rdc(SCR_IDX_STATUS, 8'hFF, 8'h40);
    rdc(SCR_IDX_CTRL, 8'hFF, 8'h00);
    rdc(SCR_IDX_MODE, 8'h03, 8'h00);
    rdc(SCR_IDX_IRQ, 8'hFF, 8'h00);
    rdc(6'h00, 8'hFF, 8'h00);
    rdc(6'h3F, 8'hFF, 8'h00);
    avs_byteenable_i <= 4'hE;
    wr(SCR_IDX_CTRL, 8'h80);
    avs_byteenable_i <= 4'hF;
    rdc(SCR_IDX_CTRL, 8'hFF, 8'h00);
    wr(SCR_IDX_CNT_LO, 8'h00);
    wr(SCR_IDX_LOAD, 8'h10);
    rdc(SCR_IDX_CNT_HI, 8'hFF, 8'h0F);
    repeat (4200) @(posedge sys_clk_i);
    rdc(SCR_IDX_IRQ, 8'h10, 8'h10);
    rdc(SCR_IDX_CNT_HI, 8'hFF, 8'h0F);
    rdc(SCR_IDX_CNT_LO, 8'h00, 8'h00);
    rdc(SCR_IDX_IRQ, 8'h10, 8'h00);
    repeat (4200) @(posedge sys_clk_i);
    wr(SCR_IDX_LOAD, 8'h10);
    rdc(SCR_IDX_IRQ, 8'h10, 8'h00);
    // Latch 1 gives 32-cycle bits; mode 1 would stall an unforced counter
    wr(SCR_IDX_CNT_LO, 8'h01);
    wr(SCR_IDX_LOAD, 8'h00);
    wr(SCR_IDX_MODE, 8'h01);
    for (int n = 0; n < 4; n++) begin
      len = n + 5;
      pe = n[0];
      odd = (n == 3);
      dat = 8'hA5 ^ 8'(n * 17);
      m = ~(8'hFF << len);
      p = ^(dat & m) ^ odd;
      exp_f = {2'b00, dat & m} | (10'(pe ? {1'b1, p} : 2'b11) << len);
      wr(SCR_IDX_CTRL, {4'h8, pe, odd, 2'(n)});
      wr(SCR_IDX_DATA, dat);
      scr_remote_node_i.recv_async(len, got);
      check({22'h0, got}, {22'h0, exp_f});
    end
    rdc(SCR_IDX_STATUS, 8'hE0, 8'hC0);
    rdc(SCR_IDX_IRQ, 8'h80, 8'h80);
    wr(SCR_IDX_IRQ, 8'h02);
    // Enable lands at the accept edge, the registered request one edge later
    repeat (2) @(posedge sys_clk_i);
    check({31'h0, irq_o}, 32'h1);
    wr(SCR_IDX_DATA, 8'h3C);
    repeat (4) @(posedge sys_clk_i);
    check({31'h0, irq_o}, 32'h0);
    wr(SCR_IDX_IRQ, 8'h00);
    wr(SCR_IDX_STATUS, 8'h20);
    rdc(SCR_IDX_STATUS, 8'hF0, 8'h20);
    scr_remote_node_i.recv_async(8, got);
    rdc(SCR_IDX_STATUS, 8'hE0, 8'hE0);
    wr(SCR_IDX_CTRL, 8'hA0);
    wr(SCR_IDX_DATA, 8'h5B);
    scr_remote_node_i.recv_shift(g8);
    check({24'h0, g8}, 32'h5B);
    repeat (48) @(posedge sys_clk_i);
    check({30'h0, txd_o, counter_a_pin_o}, 32'h3);
    rdc(SCR_IDX_STATUS, 8'h80, 8'h80);
    wr(SCR_IDX_CTRL, 8'h43);
    wr(SCR_IDX_IRQ, 8'h01);
    scr_remote_node_i.send_async(8'h96, 8, 1'b0, 1'b0, 1'b1);
    rdc(SCR_IDX_STATUS, 8'h0F, 8'h01);
    check({31'h0, irq_o}, 32'h1);
    rdc(SCR_IDX_DATA, 8'hFF, 8'h96);
    rdc(SCR_IDX_STATUS, 8'h0F, 8'h00);
    check({31'h0, irq_o}, 32'h0);
    scr_remote_node_i.send_async(8'h11, 8, 1'b0, 1'b0, 1'b1);
    scr_remote_node_i.send_async(8'h22, 8, 1'b0, 1'b0, 1'b1);
    rdc(SCR_IDX_STATUS, 8'h0F, 8'h03);
    rdc(SCR_IDX_DATA, 8'hFF, 8'h22);
    scr_remote_node_i.send_async(8'h5A, 8, 1'b0, 1'b0, 1'b0);
    rdc(SCR_IDX_STATUS, 8'h0F, 8'h08);
    bus(1'b0, SCR_IDX_DATA, 8'h00);
    wr(SCR_IDX_CTRL, 8'h4B);
    scr_remote_node_i.send_async(8'h07, 8, 1'b1, 1'b0, 1'b1);
    rdc(SCR_IDX_STATUS, 8'h0F, 8'h04);
    bus(1'b0, SCR_IDX_DATA, 8'h00);
    scr_remote_node_i.hold(1'b0, 8);
    scr_remote_node_i.hold(1'b1, 64);
    rdc(SCR_IDX_STATUS, 8'h0F, 8'h00);
    wr(SCR_IDX_STATUS, 8'h10);
    scr_remote_node_i.send_async(8'h00, 8, 1'b1, 1'b0, 1'b1);
    rdc(SCR_IDX_STATUS, 8'h1F, 8'h10);
    repeat (400) @(posedge sys_clk_i);
    rdc(SCR_IDX_STATUS, 8'h10, 8'h00);
    wr(SCR_IDX_CTRL, 8'h0B);
    scr_remote_node_i.send_async(8'h33, 8, 1'b1, 1'b0, 1'b1);
    rdc(SCR_IDX_STATUS, 8'h0F, 8'h00);
    wr(SCR_IDX_CTRL, 8'h50);
    scr_remote_node_i.send_shift(8'hC3);
    repeat (8) @(posedge sys_clk_i);
    rdc(SCR_IDX_STATUS, 8'h0F, 8'h01);
    rdc(SCR_IDX_DATA, 8'hFF, 8'hC3);
    give_verdict();
  end
endmodule
bind scr_serial_channel scr_serial_channel_sva scr_serial_channel_sva_i (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .rxd_i(rxd_i), .txd_o(txd_o),
  .counter_a_pin_i(counter_a_pin_i), .counter_a_pin_o(counter_a_pin_o),
  .counter_a_pin_oe_o(counter_a_pin_oe_o), .irq_o(irq_o));
`default_nettype wire
